/* verilog/lsem_top.sv */
// Line status event monitor: loopback code qualification, clock loss, interrupts
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps

// Behaviour
// R1 - Activate flag low without code; high after code held beyond qualification time.
// R2 - With auto remote loop off, qualification time is 40 ms.
// R3 - With auto remote loop on, qualification time is 5.1 s.
// R4 - Rising activate flag closes the remote loopback.
// R5 - Deactivate flag rises after qualified code and holds while code stays.
// R6 - Rising deactivate flag opens the remote loopback.
// R7 - Activate interrupt on rise, or any change when its edge select is set.
// R8 - Deactivate interrupt on rise, or any change when its edge select is set.
// R9 - Pattern sync flag shows receiver lock in real time.
// R10 - Pattern sync interrupt on rise, or any change with edge select set.
// R11 - Clock loss flag set when transmit clock idle over 70 cycles.
// R12 - Clock loss interrupt on rise, or any change with edge select set.
// R13 - All interrupt mask bits reset to one.
// R14 - Reading the interrupt status clears its flags and the request.
// R15 - Loss counter restarts on every synchronised transmit clock edge.
module lsem_top
  import lsem_pkg::*;
#(
  parameter int unsigned QUAL_SHORT_CYC = LSEM_QUAL_SHORT_CYC,
  parameter int unsigned QUAL_LONG_CYC  = LSEM_QUAL_LONG_CYC
)
(
  input  wire logic       CLK_I,
  input  wire logic       RESET_N_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       LOOP_ACT_CODE_I,
  input  wire logic       LOOP_DEACT_CODE_I,
  input  wire logic       PATTERN_LOCK_I,
  input  wire logic       TRANSMIT_CLOCK_IN_I,
  output logic            REMOTE_LOOP_O,
  output logic            IRQ_O
);

  lsem_state_t            s_r;
  lsem_state_t            s_nxt;
  logic [7:0]             flags;
  logic [7:0]             evt;
  logic [LSEM_QUAL_W-1:0] qual;

  // ---------------------------------------------------------------------------
  // Status byte and per-bit event detection
  // ---------------------------------------------------------------------------
  assign flags = {1'b0, s_r.act_flag, s_r.deact_flag, s_r.sync_flag, s_r.tck_loss, 3'b000};
  assign qual  = s_r.auto_remote_loop_switch ? LSEM_QUAL_W'(QUAL_LONG_CYC)    // see R3
                                             : LSEM_QUAL_W'(QUAL_SHORT_CYC);  // see R2

  // Flags are compared with their one-cycle-old copy, so the event lags by one edge
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_evt
      if (LSEM_EVT_BITS[gi])
      begin : g_used
        assign evt[gi] = s_r.edge_sel[gi] ? (flags[gi] ^ s_r.flags_d[gi])     // see R7 R8 R10 R12
                                          : (flags[gi] & ~s_r.flags_d[gi]);
      end
      else
      begin : g_none
        assign evt[gi] = 1'b0;
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;

    // Transmit clock: three stages, a level counts once stages two and three agree
    s_nxt.tck_sync = {s_r.tck_sync[1:0], TRANSMIT_CLOCK_IN_I};
    if (s_r.tck_sync[1] == s_r.tck_sync[2])
    begin
      s_nxt.tck_filt = s_r.tck_sync[2];
    end
    if (s_nxt.tck_filt != s_r.tck_filt)
    begin
      s_nxt.tck_cnt = '0;                                   // see R15
    end
    else if (s_r.tck_cnt <= LSEM_TCK_LOSS_CYC)
    begin
      s_nxt.tck_cnt = s_r.tck_cnt + 7'h01;
    end
    s_nxt.tck_loss = (s_nxt.tck_cnt > LSEM_TCK_LOSS_CYC);   // see R11

    // Loopback code qualification; a lapse in the code restarts the wait
    // A set flag holds while its code stays, so a longer wait cannot drop it
    if (LOOP_ACT_CODE_I)
    begin
      if (s_r.act_cnt < qual)
      begin
        s_nxt.act_cnt = s_r.act_cnt + LSEM_QUAL_W'(1);
      end
    end
    else
    begin
      s_nxt.act_cnt = '0;
    end
    s_nxt.act_flag = LOOP_ACT_CODE_I & (s_r.act_flag | (s_r.act_cnt >= qual));  // see R1

    if (LOOP_DEACT_CODE_I)
    begin
      if (s_r.deact_cnt < qual)
      begin
        s_nxt.deact_cnt = s_r.deact_cnt + LSEM_QUAL_W'(1);
      end
    end
    else
    begin
      s_nxt.deact_cnt = '0;
    end
    s_nxt.deact_flag = LOOP_DEACT_CODE_I & (s_r.deact_flag | (s_r.deact_cnt >= qual));  // see R5

    s_nxt.sync_flag = PATTERN_LOCK_I;                       // see R9
    s_nxt.flags_d   = flags;

    // Deactivation wins when both flags rise together: the safe state is open
    if (s_r.deact_flag & ~s_r.flags_d[LSEM_BIT_DEACT])
    begin
      s_nxt.remote_loop = 1'b0;                             // see R6
    end
    else if (s_r.act_flag & ~s_r.flags_d[LSEM_BIT_ACT])
    begin
      s_nxt.remote_loop = 1'b1;                             // see R4
    end

    // Register writes
    if (WR_I)
    begin
      if (ADDR_I == LSEM_ADDR_MASK)
      begin
        s_nxt.mask = WDATA_I & LSEM_EVT_BITS;
      end
      else if (ADDR_I == LSEM_ADDR_EDGE)
      begin
        s_nxt.edge_sel = WDATA_I & LSEM_EVT_BITS;
      end
      else if (ADDR_I == LSEM_ADDR_CTRL)
      begin
        s_nxt.auto_remote_loop_switch = WDATA_I[LSEM_BIT_AUTO];
      end
      else if (ADDR_I == LSEM_ADDR_IRQ_CLR)
      begin
        s_nxt.ists = s_r.ists & ~WDATA_I;
      end
    end

    // Register reads; data stands in the next cycle only
    s_nxt.rdata = 8'h00;
    if (RD_I)
    begin
      if (ADDR_I == LSEM_ADDR_MASK)
      begin
        s_nxt.rdata = s_r.mask;
      end
      else if (ADDR_I == LSEM_ADDR_EDGE)
      begin
        s_nxt.rdata = s_r.edge_sel;
      end
      else if (ADDR_I == LSEM_ADDR_LINE_STAT)
      begin
        s_nxt.rdata = flags;
      end
      else if (ADDR_I == LSEM_ADDR_LOOP_STAT)
      begin
        s_nxt.rdata = 8'(s_r.remote_loop) << LSEM_BIT_LOOP;
      end
      else if (ADDR_I == LSEM_ADDR_IRQ_STAT)
      begin
        s_nxt.rdata = s_r.ists;
        s_nxt.ists  = 8'h00;                                // see R14
      end
      else if (ADDR_I == LSEM_ADDR_CTRL)
      begin
        s_nxt.rdata = 8'(s_r.auto_remote_loop_switch) << LSEM_BIT_AUTO;
      end
    end

    // A new event outlives a clear in the same cycle
    s_nxt.ists = s_nxt.ists | evt;
    s_nxt.irq  = |(s_nxt.ists & ~s_nxt.mask);
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      s_r          <= '0;
      s_r.mask     <= LSEM_MASK_RST;                        // see R13
      s_r.edge_sel <= LSEM_EDGE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign RDATA_O       = s_r.rdata;
  assign REMOTE_LOOP_O = s_r.remote_loop;
  assign IRQ_O         = s_r.irq;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  a_act_no_code: assert property (!LOOP_ACT_CODE_I |=> !s_r.act_flag)              // see R1
    else $error("activate flag high without code");

  a_qual_short_time: assert property (                                             // see R2
    $rose(s_r.act_flag) && !$past(s_r.auto_remote_loop_switch)
    |-> $past(s_r.act_cnt) == QUAL_SHORT_CYC)
    else $error("short qualification time wrong");

  a_qual_long_time: assert property (                                              // see R3
    $rose(s_r.deact_flag) && $past(s_r.auto_remote_loop_switch)
    |-> $past(s_r.deact_cnt) == QUAL_LONG_CYC)
    else $error("long qualification time wrong");

  a_loop_close: assert property (                                                  // see R4
    s_r.act_flag && !s_r.flags_d[6] && !(s_r.deact_flag && !s_r.flags_d[5])
    |=> REMOTE_LOOP_O)
    else $error("remote loop not closed");

  a_deact_hold: assert property (s_r.deact_flag && LOOP_DEACT_CODE_I |=> s_r.deact_flag)  // see R5
    else $error("deactivate flag dropped");

  a_loop_open: assert property ($rose(s_r.deact_flag) |=> !REMOTE_LOOP_O)          // see R6
    else $error("remote loop not opened");

  a_act_event: assert property (                                                   // see R7
    ($rose(s_r.act_flag) || ($fell(s_r.act_flag) && s_r.edge_sel[6])) |=> s_r.ists[6])
    else $error("activate event lost");

  a_deact_event: assert property (                                                 // see R8
    $fell(s_r.deact_flag) && !s_r.edge_sel[5] && !s_r.ists[5] |=> !s_r.ists[5])
    else $error("spurious deactivate event");

  a_sync_follow: assert property (PATTERN_LOCK_I |=> s_r.sync_flag)                // see R9
    else $error("sync flag not real time");

  a_sync_event: assert property (                                                  // see R10
    $changed(s_r.sync_flag) && s_r.edge_sel[4] && !s_r.mask[4] |=> IRQ_O)
    else $error("sync interrupt missing");

  a_loss_count: assert property ($rose(s_r.tck_loss) |-> $past(s_r.tck_cnt) == 7'h46)  // see R11
    else $error("clock loss count wrong");

  a_loss_event: assert property ($rose(s_r.tck_loss) |=> s_r.ists[3])              // see R12
    else $error("clock loss event lost");

  a_mask_reset: assert property ($rose(RESET_N_I) |-> s_r.mask == 8'h78)           // see R13
    else $error("mask reset value wrong");

  a_read_clear: assert property (                                                  // see R14
    RD_I && ADDR_I == LSEM_ADDR_IRQ_STAT && evt == 8'h00 && !WR_I |=> s_r.ists == 8'h00 && !IRQ_O)
    else $error("status not cleared by read");

  a_tck_restart: assert property (                                                 // see R15
    s_nxt.tck_filt != s_r.tck_filt |=> s_r.tck_cnt == 7'h00)
    else $error("loss counter not restarted");

  a_act_hold: assert property (s_r.act_flag && LOOP_ACT_CODE_I |=> s_r.act_flag)  // see R1
    else $error("activate flag dropped");

  a_deact_no_code: assert property (!LOOP_DEACT_CODE_I |=> !s_r.deact_flag)        // see R5
    else $error("deactivate flag high without code");

  a_sync_low: assert property (!PATTERN_LOCK_I |=> !s_r.sync_flag)                 // see R9
    else $error("sync flag high without lock");

  a_loss_below_limit: assert property (                                            // see R11
    s_r.tck_cnt <= LSEM_TCK_LOSS_CYC |-> !s_r.tck_loss)
    else $error("clock loss flag too early");

  a_irq_masked: assert property ((s_r.ists & ~s_r.mask) == 8'h00 |-> !IRQ_O)      // see R13
    else $error("masked event raised interrupt");

  a_deact_rise_event: assert property ($rose(s_r.deact_flag) |=> s_r.ists[5])     // see R8
    else $error("deactivate event lost");

  a_sync_rise_event: assert property ($rose(s_r.sync_flag) |=> s_r.ists[4])       // see R10
    else $error("sync event lost");

  a_loss_fall_event: assert property (                                             // see R12
    $fell(s_r.tck_loss) && s_r.edge_sel[3] |=> s_r.ists[3])
    else $error("clock loss clear event lost");

  c_loop_closed: cover property ($rose(REMOTE_LOOP_O));
  c_loop_opened: cover property ($fell(REMOTE_LOOP_O));
  c_clock_lost:  cover property ($rose(s_r.tck_loss));
  c_irq_read:    cover property (IRQ_O && RD_I && ADDR_I == LSEM_ADDR_IRQ_STAT);
  c_sync_lost:   cover property ($fell(s_r.sync_flag) && s_r.edge_sel[4]);

endmodule : lsem_top

/* common/lsem_pkg.sv */
// Constants, register map and state type of the line status event monitor
package lsem_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned LSEM_CLK_MHZ        = 20;
  localparam int unsigned LSEM_QUAL_SHORT_US  = 40_000;     // 40 ms
  localparam int unsigned LSEM_QUAL_LONG_US   = 5_100_000;  // 5.1 s
  localparam int unsigned LSEM_QUAL_SHORT_CYC = LSEM_QUAL_SHORT_US * LSEM_CLK_MHZ;
  localparam int unsigned LSEM_QUAL_LONG_CYC  = LSEM_QUAL_LONG_US * LSEM_CLK_MHZ;
  localparam int unsigned LSEM_QUAL_W         = 27;
  localparam logic [6:0]  LSEM_TCK_LOSS_CYC   = 7'h46;      // 70 master clock cycles
  localparam int unsigned LSEM_TCK_W          = 7;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LSEM_ADDR_MASK      = 8'h14;
  localparam logic [7:0] LSEM_ADDR_EDGE      = 8'h16;
  localparam logic [7:0] LSEM_ADDR_LINE_STAT = 8'h17;
  localparam logic [7:0] LSEM_ADDR_LOOP_STAT = 8'h18;
  localparam logic [7:0] LSEM_ADDR_IRQ_STAT  = 8'h19;
  localparam logic [7:0] LSEM_ADDR_CTRL      = 8'h1B;
  localparam logic [7:0] LSEM_ADDR_IRQ_CLR   = 8'h1C;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned LSEM_BIT_ACT    = 6;
  localparam int unsigned LSEM_BIT_DEACT  = 5;
  localparam int unsigned LSEM_BIT_SYNC   = 4;
  localparam int unsigned LSEM_BIT_LOSS   = 3;
  localparam int unsigned LSEM_BIT_LOOP   = 5;
  localparam int unsigned LSEM_BIT_AUTO   = 0;
  localparam logic [7:0]  LSEM_EVT_BITS   = 8'h78;
  localparam logic [7:0]  LSEM_MASK_RST   = 8'h78;
  localparam logic [7:0]  LSEM_EDGE_RST   = 8'h00;

  typedef struct packed {
    logic [2:0]             tck_sync;
    logic                   tck_filt;
    logic [LSEM_TCK_W-1:0]  tck_cnt;
    logic                   tck_loss;
    logic [LSEM_QUAL_W-1:0] act_cnt;
    logic [LSEM_QUAL_W-1:0] deact_cnt;
    logic                   act_flag;
    logic                   deact_flag;
    logic                   sync_flag;
    logic [7:0]             flags_d;
    logic                   auto_remote_loop_switch;
    logic [7:0]             mask;
    logic [7:0]             edge_sel;
    logic [7:0]             ists;
    logic                   remote_loop;
    logic                   irq;
    logic [7:0]             rdata;
  } lsem_state_t;

endpackage : lsem_pkg

/* test/lsem_far_end.sv */
// Remote line equipment model: loopback codes, pattern lock and transmit clock
`timescale 1ns/100ps
module lsem_far_end
(
  input  wire logic clk_i,
  output logic      act_code_o,
  output logic      deact_code_o,
  output logic      lock_o,
  output logic      tck_o
);
  logic run_r;
  logic div_r;

  initial
  begin
    act_code_o   = 1'b0;
    deact_code_o = 1'b0;
    lock_o       = 1'b0;
    tck_o        = 1'b0;
    run_r        = 1'b1;
    div_r        = 1'b0;
  end

  // Transmit clock at a quarter of the master rate; it stands still when stopped
  // Each level lasts two master cycles so the pin filter sees two agreeing samples
  always @(posedge clk_i)
    if (run_r)
    begin
      div_r <= ~div_r;
      if (div_r)
        tck_o <= ~tck_o;
    end

  task automatic codes(input logic a, input logic d, input logic l);
    @(posedge clk_i);
    act_code_o   <= a;
    deact_code_o <= d;
    lock_o       <= l;
  endtask : codes

  task automatic tck_run(input logic r);
    @(posedge clk_i);
    run_r <= r;
  endtask : tck_run
endmodule : lsem_far_end

/* test/testbench.sv */
// Self-checking testbench of the line status event monitor
`timescale 1ns/100ps
module testbench;
  import lsem_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       act, deact, lock, tck, rloop, irq;
  int         miscompares = 0;
  int         cmp_count = 0;

  always #25 clk = ~clk;

  // Short qualification counts keep the run brief
  lsem_top #(.QUAL_SHORT_CYC(20), .QUAL_LONG_CYC(40)) DUT (
    .CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LOOP_ACT_CODE_I(act),
    .LOOP_DEACT_CODE_I(deact), .PATTERN_LOCK_I(lock),
    .TRANSMIT_CLOCK_IN_I(tck), .REMOTE_LOOP_O(rloop), .IRQ_O(irq));

  lsem_far_end far (.clk_i(clk), .act_code_o(act), .deact_code_o(deact),
    .lock_o(lock), .tck_o(tck));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wcyc

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rchk

  task automatic t_reset_values;
    rchk(LSEM_ADDR_MASK, 8'h78);
    rchk(LSEM_ADDR_EDGE, 8'h00);
    rchk(LSEM_ADDR_LINE_STAT, 8'h00);
    rchk(8'h00, 8'h00);
    wreg(LSEM_ADDR_MASK, 8'h00);
  endtask : t_reset_values

  task automatic t_activate_short;
    far.codes(1'b1, 1'b0, 1'b0);
    wcyc(16);
    rchk(LSEM_ADDR_LINE_STAT, 8'h00);
    wcyc(8);
    rchk(LSEM_ADDR_LINE_STAT, 8'h40);
    chk({7'h00, rloop}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rchk(LSEM_ADDR_LOOP_STAT, 8'h20);
    rchk(LSEM_ADDR_IRQ_STAT, 8'h40);
    chk({7'h00, irq}, 8'h00);
    rchk(LSEM_ADDR_IRQ_STAT, 8'h00);
  endtask : t_activate_short

  task automatic t_deactivate_long;
    wreg(LSEM_ADDR_CTRL, 8'h01);
    rchk(LSEM_ADDR_CTRL, 8'h01);
    far.codes(1'b0, 1'b1, 1'b0);
    wcyc(30);
    rchk(LSEM_ADDR_LINE_STAT, 8'h00);
    wcyc(15);
    rchk(LSEM_ADDR_LINE_STAT, 8'h20);
    chk({7'h00, rloop}, 8'h00);
    // A falling activate flag under rise-only select leaves no event
    rchk(LSEM_ADDR_IRQ_STAT, 8'h20);
    wcyc(10);
    rchk(LSEM_ADDR_LINE_STAT, 8'h20);
  endtask : t_deactivate_long

  task automatic t_edges_and_sync;
    wreg(LSEM_ADDR_EDGE, 8'h78);
    rchk(LSEM_ADDR_EDGE, 8'h78);
    far.codes(1'b0, 1'b0, 1'b1);
    wcyc(3);
    rchk(LSEM_ADDR_LINE_STAT, 8'h10);
    rchk(LSEM_ADDR_IRQ_STAT, 8'h30);
    far.codes(1'b0, 1'b0, 1'b0);
    wcyc(3);
    rchk(LSEM_ADDR_IRQ_STAT, 8'h10);
    wreg(LSEM_ADDR_EDGE, 8'h00);
    far.codes(1'b0, 1'b0, 1'b1);
    far.codes(1'b0, 1'b0, 1'b0);
    wcyc(3);
    rchk(LSEM_ADDR_IRQ_STAT, 8'h10);
  endtask : t_edges_and_sync

  task automatic t_clock_loss;
    far.tck_run(1'b0);
    wcyc(50);
    rchk(LSEM_ADDR_LINE_STAT, 8'h00);
    wcyc(30);
    rchk(LSEM_ADDR_LINE_STAT, 8'h08);
    chk({7'h00, irq}, 8'h01);
    rchk(LSEM_ADDR_IRQ_STAT, 8'h08);
    wreg(LSEM_ADDR_EDGE, 8'h08);
    far.tck_run(1'b1);
    wcyc(10);
    rchk(LSEM_ADDR_LINE_STAT, 8'h00);
    rchk(LSEM_ADDR_IRQ_STAT, 8'h08);
  endtask : t_clock_loss

  task automatic t_mask_and_clear;
    wreg(LSEM_ADDR_MASK, 8'h78);
    far.codes(1'b0, 1'b0, 1'b1);
    wcyc(3);
    #1;
    chk({7'h00, irq}, 8'h00);
    wreg(LSEM_ADDR_IRQ_CLR, 8'h10);
    rchk(LSEM_ADDR_IRQ_STAT, 8'h00);
  endtask : t_mask_and_clear

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // The scenarios need well under a thousand cycles
  initial
  begin
    #(50 * 4000);
    miscompares++;
    print_verdict();
  end

  initial
  begin
    wcyc(8);
    rst_n <= 1'b1;
    t_reset_values();
    t_activate_short();
    t_deactivate_long();
    t_edges_and_sync();
    t_clock_loss();
    t_mask_and_clear();
    print_verdict();
  end
endmodule : testbench
